// file: logic/spp_port.v
// Purpose: device side of the 4-wire serial programming port
// Assumes: prog_clk_in, load_in and shift_in_in come from the external programmer
// Notes: memory answers read data from mem_addr_out within one programming clock
//
// What this block does
// - programming mode needs opcode 0x34b shifted in during the system reset sequence.
// - opcode arrives msb first, one bit per rising programming clock edge.
// - last ten bits compared each edge; a match sets the program-mode flag.
// - no match by reset end means normal operation starts instead.
// - programming mode is left only by power loss or external reset.
// - previous response shifts out while a command shifts in; first is all zeros.
// - a write pulls serial-out low by second edge, high when done.
// - later page bytes are 8-bit frames, each latched into a buffer.
// - the 16th latched byte programs the whole code page, busy as byte write.
// - reads are single byte, latched into the response at second execute edge.
// - bit 28 selects code memory, bit 29 selects data memory space.
// - bit 24 is read when one, write when zero; other listed bits zero.
// - bit 22 requests a program memory erase.
// - bits 17 to 8 are the address, bits 7 to 0 the data.
// - response echoes previous command and its data, or the byte read.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "spp_map.vh"

module spp_port #(
   parameter CMD_W = `SPP_CMD_W,
   parameter ADDR_W = `SPP_ADDR_W,
   parameter PAGE_BYTES = `SPP_PAGE_BYTES
)(
   input wire sys_clk_in,
   input wire nrst_in,
   input wire sys_reset_busy_in,
   input wire prog_clk_in,
   input wire load_in,
   input wire shift_in_in,
   input wire [7:0] mem_rdata_in,
   input wire mem_done_in,
   output wire shift_out_out,
   output wire prog_mode_out,
   output wire normal_run_out,
   output wire mem_wr_out,
   output wire mem_page_out,
   output wire mem_erase_out,
   output wire mem_code_out,
   output wire mem_data_out,
   output wire [ADDR_W-1:0] mem_addr_out,
   output wire [7:0] mem_wdata_out,
   output wire [PAGE_BYTES*8-1:0] mem_page_data_out
);

   localparam ST_SHIFT = 2'd0;
   localparam ST_EXEC = 2'd1;
   localparam ST_BUSY = 2'd2;

   function cmd_is_read;
      input [CMD_W-1:0] cmd;
      begin
         cmd_is_read = cmd[`SPP_BIT_READ];
      end
   endfunction

   function cmd_is_page;
      input [CMD_W-1:0] cmd;
      begin
         cmd_is_page = cmd[`SPP_BIT_PAGE] & ~cmd[`SPP_BIT_READ];
      end
   endfunction

   wire [2:0] sync_w;
   wire pclk_w;
   wire load_w;
   wire sdi_w;
   wire pclk_rise_w;
   wire [`SPP_OPC_W-1:0] opc_next_w;
   wire [`SPP_CNT_W-1:0] frame_len_w;
   wire frame_full_w;
   wire busy_on_w;

   reg pclk_d1_q;
   reg [`SPP_OPC_W-1:0] opc_q;
   reg match_q;
   reg mode_q;
   reg run_q;
   reg [1:0] state_q;
   reg [`SPP_CNT_W-1:0] bit_cnt_q;
   reg exec_cnt_q;
   reg [CMD_W-1:0] cmd_sh_q;
   reg [CMD_W-1:0] cmd_q;
   reg [CMD_W-1:0] resp_q;
   reg so_q;
   reg page_act_q;
   reg [`SPP_PAGE_IDX_W-1:0] page_idx_q;
   reg [PAGE_BYTES*8-1:0] page_buf_q;
   reg mem_wr_q;
   reg mem_page_q;
   reg mem_erase_q;
   reg mem_code_q;
   reg mem_data_q;
   reg [ADDR_W-1:0] mem_addr_q;
   reg [7:0] mem_wdata_q;

   spp_sync #(
      .W(3)
   ) u_sync (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .async_in({prog_clk_in, load_in, shift_in_in}),
      .sync_out(sync_w)
   );

   assign pclk_w = sync_w[2];
   assign load_w = sync_w[1];
   assign sdi_w = sync_w[0];
   assign pclk_rise_w = pclk_w & ~pclk_d1_q;
   assign opc_next_w = {opc_q[`SPP_OPC_W-2:0], sdi_w};
   assign frame_len_w = page_act_q ? `SPP_BYTE_BITS : `SPP_CMD_BITS;
   assign frame_full_w = (bit_cnt_q == frame_len_w);
   // busy is raised at the first execute edge, before the second
   assign busy_on_w = page_act_q ? (page_idx_q == `SPP_PAGE_LAST)
                      : (~cmd_is_read(cmd_sh_q) & ~cmd_is_page(cmd_sh_q));

   always @(posedge sys_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         pclk_d1_q <= 1'b0;
      end
      else
      begin
         pclk_d1_q <= pclk_w;
      end
   end

   // entry opcode capture during the reset sequence
   always @(posedge sys_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         opc_q <= {`SPP_OPC_W{1'b0}};
         match_q <= 1'b0;
         mode_q <= 1'b0;
         run_q <= 1'b0;
      end
      else if (!mode_q && !run_q)
      begin
         if (sys_reset_busy_in)
         begin
            if (pclk_rise_w)
            begin
               opc_q <= opc_next_w;
               if (opc_next_w == `SPP_OPC_VAL)
               begin
                  match_q <= 1'b1;
               end
            end
         end
         else if (match_q)
         begin
            mode_q <= 1'b1;
         end
         else
         begin
            run_q <= 1'b1;
         end
      end
   end

   // command protocol; mode_q only falls with nrst_in
   always @(posedge sys_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         state_q <= ST_SHIFT;
         bit_cnt_q <= {`SPP_CNT_W{1'b0}};
         exec_cnt_q <= 1'b0;
         cmd_sh_q <= {CMD_W{1'b0}};
         cmd_q <= {CMD_W{1'b0}};
         resp_q <= `SPP_RESP_RST;
         so_q <= `SPP_SO_IDLE;
         page_act_q <= 1'b0;
         page_idx_q <= {`SPP_PAGE_IDX_W{1'b0}};
         page_buf_q <= {PAGE_BYTES*8{1'b0}};
         mem_wr_q <= 1'b0;
         mem_page_q <= 1'b0;
         mem_erase_q <= 1'b0;
         mem_code_q <= 1'b0;
         mem_data_q <= 1'b0;
         mem_addr_q <= {ADDR_W{1'b0}};
         mem_wdata_q <= 8'h00;
      end
      else
      begin
         mem_wr_q <= 1'b0;
         if (mode_q)
         begin
            case (state_q)
               ST_SHIFT:
               begin
                  if (pclk_rise_w && load_w && !frame_full_w)
                  begin
                     cmd_sh_q <= {cmd_sh_q[CMD_W-2:0], sdi_w};
                     if (!page_act_q)
                     begin
                        so_q <= resp_q[CMD_W-1];
                        resp_q <= {resp_q[CMD_W-2:0], 1'b0};
                     end
                     bit_cnt_q <= bit_cnt_q + 1'b1;
                  end
                  else if (!load_w && frame_full_w)
                  begin
                     state_q <= ST_EXEC;
                     exec_cnt_q <= 1'b0;
                  end
               end
               ST_EXEC:
               begin
                  if (pclk_rise_w && !load_w && !exec_cnt_q)
                  begin
                     exec_cnt_q <= 1'b1;
                     if (!page_act_q)
                     begin
                        cmd_q <= cmd_sh_q;
                        mem_addr_q <= cmd_sh_q[`SPP_ADDR_HI:`SPP_ADDR_LO];
                        mem_code_q <= cmd_sh_q[`SPP_BIT_CSPACE];
                        mem_data_q <= cmd_sh_q[`SPP_BIT_DSPACE];
                     end
                     if (busy_on_w)
                     begin
                        so_q <= 1'b0;
                     end
                  end
                  else if (pclk_rise_w && !load_w && exec_cnt_q)
                  begin
                     bit_cnt_q <= {`SPP_CNT_W{1'b0}};
                     state_q <= ST_SHIFT;
                     if (page_act_q)
                     begin
                        page_buf_q[page_idx_q*8 +: 8] <= cmd_sh_q[`SPP_DATA_HI:`SPP_DATA_LO];
                        if (page_idx_q == `SPP_PAGE_LAST)
                        begin
                           mem_wr_q <= 1'b1;
                           mem_page_q <= 1'b1;
                           mem_erase_q <= 1'b0;
                           page_act_q <= 1'b0;
                           state_q <= ST_BUSY;
                        end
                        else
                        begin
                           page_idx_q <= page_idx_q + 1'b1;
                        end
                     end
                     else if (cmd_is_read(cmd_q))
                     begin
                        resp_q <= {cmd_q[CMD_W-1:`SPP_ECHO_LO], mem_rdata_in};
                     end
                     else if (cmd_is_page(cmd_q))
                     begin
                        page_buf_q[7:0] <= cmd_q[`SPP_DATA_HI:`SPP_DATA_LO];
                        page_idx_q <= `SPP_PAGE_FIRST;
                        page_act_q <= 1'b1;
                        resp_q <= cmd_q;
                     end
                     else
                     begin
                        mem_wdata_q <= cmd_q[`SPP_DATA_HI:`SPP_DATA_LO];
                        mem_erase_q <= cmd_q[`SPP_BIT_ERASE];
                        mem_page_q <= 1'b0;
                        mem_wr_q <= 1'b1;
                        resp_q <= cmd_q;
                        state_q <= ST_BUSY;
                     end
                  end
               end
               ST_BUSY:
               begin
                  // pin edges are dropped here
                  if (mem_done_in)
                  begin
                     so_q <= 1'b1;
                     bit_cnt_q <= {`SPP_CNT_W{1'b0}};
                     state_q <= ST_SHIFT;
                  end
               end
               default:
               begin
                  state_q <= ST_SHIFT;
               end
            endcase
         end
      end
   end

   assign shift_out_out = so_q;
   assign prog_mode_out = mode_q;
   assign normal_run_out = run_q;
   assign mem_wr_out = mem_wr_q;
   assign mem_page_out = mem_page_q;
   assign mem_erase_out = mem_erase_q;
   assign mem_code_out = mem_code_q;
   assign mem_data_out = mem_data_q;
   assign mem_addr_out = mem_addr_q;
   assign mem_wdata_out = mem_wdata_q;
   assign mem_page_data_out = page_buf_q;

endmodule

// file: logic/spp_map.vh
// Purpose: constants of the serial programming port
// Assumes: included by every design file of the port
// Notes: bit positions refer to the 32-bit command and response word
`ifndef SPP_MAP_VH
`define SPP_MAP_VH

// entry opcode
`define SPP_OPC_W 10
`define SPP_OPC_VAL 10'h34b

// word and byte lengths
`define SPP_CMD_W 32
`define SPP_BYTE_W 8
`define SPP_CNT_W 6
`define SPP_CMD_BITS 6'h20
`define SPP_BYTE_BITS 6'h08

// page buffer
`define SPP_PAGE_BYTES 16
`define SPP_PAGE_IDX_W 4
`define SPP_PAGE_LAST 4'hf
`define SPP_PAGE_FIRST 4'h1

// command word fields
`define SPP_BIT_PAGE 31
`define SPP_BIT_DSPACE 29
`define SPP_BIT_CSPACE 28
`define SPP_BIT_READ 24
`define SPP_BIT_ERASE 22
`define SPP_ADDR_HI 17
`define SPP_ADDR_LO 8
`define SPP_ADDR_W 10
`define SPP_DATA_HI 7
`define SPP_DATA_LO 0
`define SPP_ECHO_LO 8

// serial timing, kept for reference of the sampling margin
`define SPP_INPUT_SETUP_NS 100
`define SPP_SYS_CLK_NS 25

// reset values
`define SPP_SO_IDLE 1'b1
`define SPP_RESP_RST 32'h00000000

`endif

// file: logic/spp_sync.v
// Purpose: two-stage synchroniser for the programming pins
// Assumes: inputs come from outside the sys_clk_in domain
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
`include "spp_map.vh"

module spp_sync #(
   parameter W = 3
)(
   input wire sys_clk_in,
   input wire nrst_in,
   input wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_bit
         always @(posedge sys_clk_in or negedge nrst_in)
         begin
            if (!nrst_in)
            begin
               meta_q[i] <= 1'b0;
               sync_q[i] <= 1'b0;
            end
            else
            begin
               meta_q[i] <= async_in[i];
               sync_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   assign sync_out = sync_q;

endmodule

// file: tb/spp_port_monitor.sv
// Purpose: assertions on the programming port
// Assumes: bound to spp_port
// Notes: busy_q follows a write until done
`timescale 1ns/100ps
module spp_port_monitor #(
   parameter ADDR_W = 10
)(
   input wire sys_clk_in,
   input wire nrst_in,
   input wire sys_reset_busy_in,
   input wire mem_done_in,
   input wire shift_out_out,
   input wire prog_mode_out,
   input wire normal_run_out,
   input wire mem_wr_out,
   input wire [ADDR_W-1:0] mem_addr_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);
   logic busy_q;
   always @(posedge sys_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         busy_q <= 1'b0;
      else if (mem_wr_out)
         busy_q <= 1'b1;
      else if (mem_done_in)
         busy_q <= 1'b0;
   end
   sequence s_wait;
      busy_q && !mem_done_in;
   endsequence
   sequence s_done;
      busy_q && mem_done_in;
   endsequence
   property p_wr_low;
      mem_wr_out |-> !shift_out_out;
   endproperty
   property p_hold;
      s_wait |=> !shift_out_out;
   endproperty
   property p_rel;
      s_done |=> shift_out_out;
   endproperty
   property p_pulse;
      mem_wr_out |=> !mem_wr_out;
   endproperty
   property p_addr;
      s_wait |=> $stable(mem_addr_out);
   endproperty
   property p_excl;
      !(prog_mode_out && normal_run_out);
   endproperty
   property p_stay;
      prog_mode_out |=> prog_mode_out;
   endproperty
   property p_entry;
      $fell(sys_reset_busy_in) |=> prog_mode_out || normal_run_out;
   endproperty
   property p_nocmd;
      !prog_mode_out |-> !mem_wr_out;
   endproperty
   a_wr_low: assert property (p_wr_low) else $error("write not busy");
   a_hold: assert property (p_hold) else $error("busy dropped");
   a_rel: assert property (p_rel) else $error("busy stuck");
   a_pulse: assert property (p_pulse) else $error("long write");
   a_addr: assert property (p_addr) else $error("addr moved");
   a_excl: assert property (p_excl) else $error("two modes");
   a_stay: assert property (p_stay) else $error("mode left");
   a_entry: assert property (p_entry) else $error("no mode");
   a_nocmd: assert property (p_nocmd) else $error("early write");
endmodule
bind spp_port spp_port_monitor #(.ADDR_W(ADDR_W)) u_mon (.sys_clk_in, .nrst_in,
   .sys_reset_busy_in, .mem_done_in, .shift_out_out, .prog_mode_out, .normal_run_out,
   .mem_wr_out, .mem_addr_out);

// file: tb/spp_pgm.sv
// Purpose: programmer side of the port
// Assumes: 200 ns link clock, low when idle
// Notes: tasks called by the bench
`timescale 1ns/100ps
module spp_pgm (
   output logic clk_out,
   output logic load_out,
   output logic sdi_out,
   input wire logic so_in
);
   initial
   begin
      clk_out = 1'b0;
      load_out = 1'b0;
      sdi_out = 1'b0;
   end
   task automatic shift(input logic [31:0] w, input int n, output logic [31:0] r);
      r = 32'h0;
      for (int i = n - 1; i >= 0; i--)
      begin
         sdi_out <= w[i];
         #50 clk_out <= 1'b1;
         #100 clk_out <= 1'b0;
         #50 r = {r[30:0], so_in};
      end
      sdi_out <= ~sdi_out;
   endtask
   task automatic frame(input logic [31:0] w, input int n, output logic [31:0] r);
      load_out <= 1'b1;
      #100 shift(w, n, r);
   endtask
   task automatic exec(output logic bz);
      load_out <= 1'b0;
      #100;
      repeat (2)
      begin
         #50 clk_out <= 1'b1;
         #100 clk_out <= 1'b0;
         #50;
      end
      bz = so_in;
      for (int k = 0; k < 400 && so_in !== 1'b1; k++) #25;
   endtask
endmodule

// file: tb/tb.sv
// Purpose: self-checking bench of the port
// Assumes: bench answers as memory
// Notes: random commands, fixed seed
`timescale 1ns/100ps
`include "spp_map.vh"
module tb;
   logic sys_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic sys_reset_busy_in = 1'b1;
   logic prog_clk_in, load_in, shift_in_in, mem_done_in = 1'b0;
   logic [7:0] mem_rdata_in = 8'h00;
   logic shift_out_out, prog_mode_out, normal_run_out, mem_wr_out, mem_page_out;
   logic mem_erase_out, mem_code_out, mem_data_out;
   logic [9:0] mem_addr_out;
   logic [7:0] mem_wdata_out, dcnt = 8'h00;
   logic [127:0] mem_page_data_out, pg;
   logic [149:0] cap;
   logic [31:0] c, v, r, exp_r;
   logic bz;
   integer seed = 2567, num_errors = 0, n_checks = 0, n_wr = 0;
   initial forever #12.5 sys_clk_in = ~sys_clk_in;
   spp_port uut (.sys_clk_in, .nrst_in, .sys_reset_busy_in, .prog_clk_in, .load_in,
      .shift_in_in, .mem_rdata_in, .mem_done_in, .shift_out_out, .prog_mode_out,
      .normal_run_out, .mem_wr_out, .mem_page_out, .mem_erase_out, .mem_code_out,
      .mem_data_out, .mem_addr_out, .mem_wdata_out, .mem_page_data_out);
   spp_pgm pgm (.clk_out(prog_clk_in), .load_out(load_in), .sdi_out(shift_in_in),
      .so_in(shift_out_out));
   function automatic logic [7:0] rdf(input logic [9:0] a);
      return a[7:0] ^ {6'h2d, a[9:8]};
   endfunction
   function automatic logic [31:0] mk(input logic p, d, cs, rd, e, input logic [9:0] a,
      input logic [7:0] x);
      return {p, 1'b0, d, cs, 3'h0, rd, 1'b0, e, 4'h0, a, x};
   endfunction
   // memory stand-in
   always @(posedge sys_clk_in)
   begin
      mem_rdata_in <= rdf(mem_addr_out);
      mem_done_in <= (dcnt == 8'h01);
      dcnt <= mem_wr_out ? 8'h14 : (dcnt != 8'h00 ? dcnt - 8'h01 : 8'h00);
      if (mem_wr_out)
      begin
         n_wr <= n_wr + 1;
         cap <= {mem_page_out, mem_erase_out, mem_code_out, mem_data_out,
            mem_addr_out, mem_wdata_out, mem_page_data_out};
      end
   end
   task automatic chk(input logic [159:0] g, e);
      n_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic do_reset;
      @(posedge sys_clk_in);
      nrst_in <= 1'b0;
      sys_reset_busy_in <= 1'b1;
      repeat (5) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
   endtask
   task automatic enter(input logic [9:0] op, input logic ok);
      do_reset();
      pgm.shift({17'h0, 5'h15, op}, 15, r);
      @(posedge sys_clk_in);
      sys_reset_busy_in <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
      chk({prog_mode_out, normal_run_out}, {ok, ~ok});
      exp_r = 32'h0;
   endtask
   task automatic run(input logic [31:0] w);
      int k;
      pgm.frame(w, 32, r);
      chk(r, exp_r);
      k = n_wr;
      pgm.exec(bz);
      if (w[24])
      begin
         chk(n_wr - k, 0);
         exp_r = {w[31:8], rdf(w[17:8])};
      end
      else
      begin
         chk({bz, n_wr - k, cap[149:128]}, {1'b0, 32'd1, 1'b0, w[22], w[28], w[29], w[17:0]});
         exp_r = w;
      end
   endtask
   initial
   begin
      enter(10'h34a, 1'b0);
      enter(`SPP_OPC_VAL, 1'b1);
      run(mk(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 10'h3ff, 8'hff));
      run(mk(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 10'h3ff, 8'h00));
      repeat (14)
      begin
         v = $random(seed);
         run(mk(1'b0, v[9], ~v[9], v[8], ~v[8] & v[10] & v[11], v[21:12], v[8] ? 8'h00 : v[7:0]));
      end
      pg = {$random(seed), $random(seed), $random(seed), $random(seed)};
      v = $random(seed);
      c = mk(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, {v[5:0], 4'h0}, pg[7:0]);
      pgm.frame(c, 32, r);
      chk(r, exp_r);
      pgm.exec(bz);
      for (int i = 1; i < 16; i++)
      begin
         pgm.frame({24'h0, pg[8*i+:8]}, 8, r);
         pgm.exec(bz);
      end
      chk({bz, cap[149], cap[145:136], cap[127:0]}, {2'b01, c[17:8], pg});
      exp_r = c;
      run(mk(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 10'h000, 8'h00));
      run(mk(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 10'h000, 8'h00));
      chk(prog_mode_out, 1'b1);
      do_reset();
      chk(prog_mode_out, 1'b0);
      summarize();
   end
   initial
   begin
      #2000000;
      num_errors++;
      summarize();
   end
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
endmodule
